// ### src/axil_slave.sv
`timescale 1ns/1ps
module axil_slave
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [wdt_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [wdt_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [wdt_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [wdt_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	regbus_if.initiator rb
);
	import wdt_pkg::*;

	logic aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [DATA_W-1:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [DATA_W-1:0] rdata_q, rdata_d;
	logic fire;

	// ==========================================
	// Write path: address and data in either order
	always_comb
	begin
		fire = aw_have_q && w_have_q && !bvalid_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (awvalid && awready_q)
		begin
			aw_have_d = 1'b1;
			awaddr_d = awaddr;
		end
		if (wvalid && wready_q)
		begin
			w_have_d = 1'b1;
			wdata_d = wdata;
			wstrb_d = wstrb;
		end
		if (bvalid_q && bready)
			bvalid_d = 1'b0;
		if (fire)
		begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = rb.wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		awready_d = !aw_have_d && !bvalid_d;
		wready_d = !w_have_d && !bvalid_d;
		rb.wr_en = fire;
		rb.wr_addr = awaddr_q;
		rb.wr_data = wdata_q;
		rb.wr_strb = wstrb_q;
	end

	// ==========================================
	// Read path: data sampled at the address edge
	always_comb
	begin
		rb.rd_en = arvalid && arready_q;
		rb.rd_addr = araddr;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && rready)
			rvalid_d = 1'b0;
		if (rb.rd_en)
		begin
			rvalid_d = 1'b1;
			rdata_d = rb.rd_data;
			rresp_d = rb.rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
endmodule

// ### src/regbus_if.sv
`timescale 1ns/1ps
interface regbus_if;
	import wdt_pkg::*;
	logic wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic rd_en;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic rd_err;

	modport initiator
	(
		output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_err, rd_data, rd_err
	);
	modport target
	(
		input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_err, rd_data, rd_err
	);
endinterface

// ### src/watchdog_timer.sv
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// Notes on behaviour
// [R1]: Binary counter on system clock; overflow after 2^15..2^25 clocks.
// [R2]: Action bit 0: overflow raises the non-maskable interrupt.
// [R3]: Interrupt also sets the watchdog flag in the NMI source register.
// [R4]: Action bit 1: overflow resets the chip for 32 states, clock to internal oscillator.
// [R5]: Overflow drives fault output low; clear code returns it high.
// [R6]: Command byte: B1 disables, 4E clears, others do nothing.
// [R7]: Counting starts right after reset with no software help.
// [R8]: In idle the idle-run bit decides whether counting continues.
// [R9]: Software disables the watchdog before either deep stop mode.
// [R10]: Counter holds still while the processor is in debug.
// [R11]: Period select is software written and resets to 000.
// [R12]: Enable bit resets to 1; watchdog runs after every reset.
// [R13]: Disable: clear enable, then write B1; counter stops and clears.
// [R14]: Setting enable to 1 again resumes counting.
// [R15]: Action bit resets to 1, so overflow gives an internal reset.
// [R16]: Software writes the clear code before each overflow.
// [R17]: Period codes 000..101 in steps of two powers; 110 and 111 prohibited.
// [R18]: Idle-run bit 0 stops the counter in idle, 1 keeps it running.
// [R19]: Disable code is ignored while the enable bit is still 1.
module watchdog_timer
#(
	parameter int BASE_SHIFT = wdt_pkg::BASE_SHIFT
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [wdt_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire logic [wdt_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [wdt_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output logic [wdt_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic idle_mode,
	input wire logic debug_mode,
	output logic overflow_interrupt,
	output logic nmi_source0_flag_set,
	output logic sys_reset_req,
	output logic clock_to_internal_osc,
	output logic fault_output_n
);
	import wdt_pkg::*;

	localparam int CNT_W = BASE_SHIFT + 10;

	regbus_if rb();

	wdt_state_t state_q, state_d;
	logic [7:0] mode_q, mode_d;
	logic [HOLD_W-1:0] hold_cnt_q, hold_cnt_d;
	logic fault_n_q, fault_n_d;
	logic nmi_q, nmi_d;
	logic rst_req_q, rst_req_d;
	logic [CNT_W-1:0] count;
	logic ovf, run, clr_cnt;
	logic mode_wr, cmd_wr, code_clear, code_disable;
	logic enable_bit, idle_run, action_reset;

	// ==========================================
	// Bus slave
	axil_slave u_bus
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.rb(rb)
	);

	// ==========================================
	// Register decode
	always_comb
	begin
		// Only byte lane 0 carries the fields; other lanes are read-as-zero
		mode_wr = rb.wr_en && rb.wr_addr == MODE_OFS && rb.wr_strb[0];
		cmd_wr = rb.wr_en && rb.wr_addr == CMD_OFS && rb.wr_strb[0];
		code_clear = cmd_wr && rb.wr_data[7:0] == CODE_CLEAR; // [R6]
		code_disable = cmd_wr && rb.wr_data[7:0] == CODE_DISABLE; // [R6]
		rb.wr_err = !(rb.wr_addr == MODE_OFS || rb.wr_addr == CMD_OFS
			|| rb.wr_addr == STATUS_OFS);
		rb.rd_err = 1'b0;
		rb.rd_data = '0;
		case (rb.rd_addr)
			MODE_OFS:
				rb.rd_data = {24'h00_0000, mode_q};
			CMD_OFS:
				rb.rd_data = '0;
			STATUS_OFS:
			begin
				rb.rd_data[STAT_OFF_BIT] = state_q == ST_OFF;
				rb.rd_data[STAT_FAULT_BIT] = !fault_n_q;
				rb.rd_data[STAT_HOLD_BIT] = state_q == ST_HOLD;
			end
			default:
				rb.rd_err = 1'b1;
		endcase
	end

	assign enable_bit = mode_q[MODE_EN_BIT];
	assign idle_run = mode_q[MODE_IDLE_BIT];
	assign action_reset = mode_q[MODE_ACT_BIT];

	// ==========================================
	// Counter
	always_comb
	begin
		// Debug and idle gate the count; software registers stay live
		run = state_q == ST_RUN && !debug_mode // [R7] [R10]
			&& (!idle_mode || idle_run); // [R8] [R18]
		clr_cnt = state_q != ST_RUN || code_clear
			|| (code_disable && !enable_bit); // [R13]
	end

	wdt_counter #(.BASE(BASE_SHIFT), .CNT_W(CNT_W)) u_cnt
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.run(run),
		.clear(clr_cnt),
		.period_sel(mode_q[MODE_PER_LSB +: MODE_PER_W]), // [R11]
		.count(count),
		.overflow(ovf)
	);

	// ==========================================
	// Control state
	always_comb
	begin
		state_d = state_q;
		mode_d = mode_q;
		hold_cnt_d = hold_cnt_q;
		fault_n_d = fault_n_q;
		nmi_d = 1'b0;
		rst_req_d = rst_req_q;
		if (mode_wr)
			mode_d = rb.wr_data[7:0] & MODE_WMASK;
		// Clear first so a same-cycle overflow still pulls the output low
		if (code_clear && state_q != ST_HOLD)
			fault_n_d = 1'b1; // [R5]
		case (state_q)
			ST_RUN:
			begin
				if (ovf)
				begin
					fault_n_d = 1'b0; // [R5]
					if (action_reset)
					begin
						state_d = ST_HOLD; // [R4]
						hold_cnt_d = '0;
						rst_req_d = 1'b1;
					end
					else
						nmi_d = 1'b1; // [R2] [R3]
				end
				else if (code_disable && !enable_bit) // [R13] [R19]
					state_d = ST_OFF;
			end
			ST_OFF:
			begin
				// Enable write wins over a disable code in the same word order
				if (mode_wr && rb.wr_data[MODE_EN_BIT])
					state_d = ST_RUN; // [R14]
			end
			ST_HOLD:
			begin
				hold_cnt_d = hold_cnt_q + HOLD_W'(1);
				if (hold_cnt_q == HOLD_W'(HOLD_STATES - 1)) // [R4]
				begin
					// The chip-wide reset also restores this block
					state_d = ST_RUN;
					rst_req_d = 1'b0;
					mode_d = MODE_RST;
					fault_n_d = 1'b1;
					hold_cnt_d = '0;
				end
			end
			default:
			begin
				state_d = ST_RUN;
				rst_req_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= ST_RUN; // [R7]
			mode_q <= MODE_RST; // [R11] [R12] [R15]
			hold_cnt_q <= '0;
			fault_n_q <= 1'b1;
			nmi_q <= 1'b0;
			rst_req_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			mode_q <= mode_d;
			hold_cnt_q <= hold_cnt_d;
			fault_n_q <= fault_n_d;
			nmi_q <= nmi_d;
			rst_req_q <= rst_req_d;
		end
	end

	assign overflow_interrupt = nmi_q;
	assign nmi_source0_flag_set = nmi_q;
	assign sys_reset_req = rst_req_q;
	assign clock_to_internal_osc = rst_req_q;
	assign fault_output_n = fault_n_q;

	// ==========================================
	// Checks
	logic [HOLD_W:0] hold_len_q, hold_len_d;

	always_comb
	begin
		hold_len_d = rst_req_q ? hold_len_q + (HOLD_W+1)'(1) : '0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			hold_len_q <= '0;
		else
			hold_len_q <= hold_len_d;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_reset_values: assert property ($rose(aresetn) |-> mode_q == MODE_RST // [R11] [R12] [R15]
		&& state_q == ST_RUN) else $error("wrong state after reset");
	a_nmi_on_ovf: assert property (ovf && !action_reset && state_q == ST_RUN // [R2] [R3]
		|=> overflow_interrupt && nmi_source0_flag_set ##1 !overflow_interrupt)
		else $error("interrupt not raised on overflow");
	a_reset_hold_len: assert property ($fell(sys_reset_req) // [R4]
		|-> hold_len_q == (HOLD_W+1)'(HOLD_STATES) && !clock_to_internal_osc)
		else $error("internal reset hold length wrong");
	a_reset_on_ovf: assert property (ovf && action_reset |=> sys_reset_req // [R4]
		&& !overflow_interrupt) else $error("internal reset not raised");
	a_fault_on_ovf: assert property (ovf |=> !fault_output_n) // [R5]
		else $error("fault output not low after overflow");
	a_fault_clear: assert property (code_clear && !ovf && state_q != ST_HOLD // [R5] [R6]
		|=> fault_output_n && count == '0) else $error("clear code did not act");
	a_disable_apply: assert property (code_disable && !enable_bit && state_q == ST_RUN // [R13]
		&& !ovf |=> state_q == ST_OFF && count == '0) else $error("disable code ignored");
	a_disable_guard: assert property (code_disable && enable_bit && state_q == ST_RUN // [R19]
		|=> state_q != ST_OFF) else $error("disable accepted with enable set");
	a_reenable: assert property (state_q == ST_OFF && mode_wr && rb.wr_data[MODE_EN_BIT] // [R14]
		|=> state_q == ST_RUN) else $error("enable did not resume counting");
	a_debug_hold: assert property (debug_mode && !clr_cnt // [R10]
		|=> count == $past(count)) else $error("counter moved in debug");
	a_idle_stop: assert property (idle_mode && !idle_run && !clr_cnt // [R8] [R18]
		|=> count == $past(count)) else $error("counter moved in idle with stop set");
	a_idle_run: assert property (idle_mode && idle_run && !debug_mode && state_q == ST_RUN // [R8]
		&& !clr_cnt && !ovf |=> count == $past(count) + CNT_W'(1))
		else $error("counter stopped in idle with run set");
endmodule

// ### src/wdt_counter.sv
`timescale 1ns/1ps
module wdt_counter
#(
	parameter int BASE = 15,
	parameter int CNT_W = BASE + 10
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic clear,
	input wire logic [2:0] period_sel,
	output logic [CNT_W-1:0] count,
	output logic overflow
);
	import wdt_pkg::*;

	logic [CNT_W-1:0] count_q, count_d, limit;
	logic [CNT_W:0] span;
	logic [2:0] sel;
	logic [5:0] shift;

	always_comb
	begin
		// Prohibited codes fall back to the longest period rather than wrap
		sel = (period_sel > PER_SEL_MAX) ? PER_SEL_MAX : period_sel; // [R17]
		shift = 6'(BASE) + 6'(sel) * 6'(PER_STEP); // [R1]
		span = (CNT_W+1)'(1) << shift;
		limit = span[CNT_W-1:0] - CNT_W'(1);
		// A shorter period chosen mid-count must still trip at once, not after a full wrap
		overflow = run && (count_q >= limit); // [R1]
		count_d = count_q;
		if (clear)
			count_d = '0;
		else if (run)
			count_d = overflow ? '0 : count_q + CNT_W'(1);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			count_q <= '0;
		else
			count_q <= count_d;
	end

	assign count = count_q;

	a_count_in_range: assert property (@(posedge aclk) disable iff (!aresetn) // [R1] [R17]
		$stable(period_sel) && $past(count_q) <= limit |-> count_q <= limit)
		else $error("count passed the overflow point");
	a_wrap_after_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
		overflow |=> count_q == '0) else $error("counter did not restart after overflow"); // [R1]
endmodule

// ### src/wdt_pkg.sv
package wdt_pkg;

	// ==========================================
	// Bus and register map
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam logic [11:0] MODE_OFS = 12'h000;
	localparam logic [11:0] CMD_OFS = 12'h004;
	localparam logic [11:0] STATUS_OFS = 12'h008;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================
	// Mode register fields
	localparam int MODE_EN_BIT = 7;
	localparam int MODE_PER_LSB = 4;
	localparam int MODE_PER_W = 3;
	localparam int MODE_IDLE_BIT = 2;
	localparam int MODE_ACT_BIT = 1;
	localparam logic [7:0] MODE_RST = 8'h82;
	localparam logic [7:0] MODE_WMASK = 8'hF7;

	// ==========================================
	// Status register fields
	localparam int STAT_OFF_BIT = 0;
	localparam int STAT_FAULT_BIT = 1;
	localparam int STAT_HOLD_BIT = 2;

	// ==========================================
	// Command codes
	localparam logic [7:0] CODE_DISABLE = 8'hB1;
	localparam logic [7:0] CODE_CLEAR = 8'h4E;

	// ==========================================
	// Timing
	localparam int BASE_SHIFT = 15;
	localparam int PER_STEP = 2;
	localparam logic [2:0] PER_SEL_MAX = 3'h5;
	localparam int HOLD_STATES = 32;
	localparam int HOLD_W = 6;

	typedef enum logic [1:0]
	{
		ST_RUN = 2'b00,
		ST_HOLD = 2'b01,
		ST_OFF = 2'b11
	} wdt_state_t;

endpackage

// ### verification/cpu_model.sv
`timescale 1ns/1ps
// ==========
// Software side of the register bus
module cpu_model
(
	input wire logic aclk,
	output logic [wdt_pkg::ADDR_W-1:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [wdt_pkg::DATA_W-1:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [wdt_pkg::ADDR_W-1:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [wdt_pkg::DATA_W-1:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	import wdt_pkg::*;
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'h0;
	end

	// Released lines show the inverse, so a stale value is never mistaken for a live one
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw;
		bit w;
		aw = 0;
		w = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge aclk);
			if (!aw && awready === 1'b1)
			begin
				aw = 1;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (!w && wready === 1'b1)
			begin
				w = 1;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		do
			@(posedge aclk);
		while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		// Let an edge pass so a following call never re-raises bready in the same step
		@(posedge aclk);
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
			@(posedge aclk);
		while (arready !== 1'b1);
		arvalid <= 1'b0;
		araddr <= ~a;
		do
			@(posedge aclk);
		while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		// Same reason as for writes: rready drops for at least one edge
		@(posedge aclk);
	endtask
endmodule

// ### verification/watchdog_timer_bench.sv
`timescale 1ns/1ps
module watchdog_timer_bench;
	import wdt_pkg::*;
	// Short base keeps the longest period at 2^13 cycles
	localparam int BASE = 3;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic idle_mode = 1'b0;
	logic debug_mode = 1'b1;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic irq, flag_set, rst_req, to_osc, fault_output_n;
	logic [31:0] rng = 32'h9401_f8e9;
	int errors = 0;
	int n_compared = 0;
	int n;
	int m;

	always #25 aclk = ~aclk;

	watchdog_timer #(.BASE_SHIFT(BASE)) DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .idle_mode(idle_mode),
		.debug_mode(debug_mode), .overflow_interrupt(irq), .nmi_source0_flag_set(flag_set),
		.sys_reset_req(rst_req), .clock_to_internal_osc(to_osc), .fault_output_n(fault_output_n));

	cpu_model cpu (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	// ==========
	// Checking helpers
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task automatic cmp_val(string what, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic cmp_resp(string what, logic [1:0] e, logic [1:0] g);
		cmp_val(what, {30'h0, e}, {30'h0, g});
	endtask

	// Counts are exact; registered outputs are seen one edge after they launch
	task automatic cmp_cyc(string what, int e, int g);
		n_compared++;
		if (g != e)
		begin
			errors++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, e, g);
		end
	endtask

	task automatic wr(logic [ADDR_W-1:0] a, logic [31:0] d);
		logic [1:0] r;
		cpu.wr(a, d, r);
		cmp_resp("write response", RESP_OKAY, r);
	endtask

	task automatic rd(logic [ADDR_W-1:0] a, logic [31:0] e, logic [1:0] er, string what);
		logic [31:0] d;
		logic [1:0] r;
		cpu.rd(a, d, r);
		cmp_resp("read response", er, r);
		cmp_val(what, e, d);
	endtask

	// Stall kind: 0 none, 1 debug, 2 idle; counter is frozen by debug between cases
	task automatic measure(int kind, int hold, int e);
		int k;
		k = 0;
		debug_mode <= (kind == 1);
		idle_mode <= (kind == 2);
		do
		begin
			@(posedge aclk);
			k++;
			if (k == hold)
			begin
				debug_mode <= 1'b0;
				idle_mode <= 1'b0;
			end
		end
		while (irq !== 1'b1 && k < 20000);
		debug_mode <= 1'b1;
		idle_mode <= 1'b0;
		cmp_cyc("interrupt delay", e + 1, k);
		cmp_val("source flag", 1, flag_set);
		cmp_val("fault pin", 0, fault_output_n);
		cmp_val("reset request", 0, rst_req);
	endtask

	task automatic run_case(int p, int ir, int kind, int hold);
		logic [31:0] md;
		md = 32'h0000_0080 | 32'(p << 4) | 32'(ir << 2);
		wr(MODE_OFS, md);
		rd(MODE_OFS, md, RESP_OKAY, "mode");
		wr(CMD_OFS, 32'(CODE_CLEAR));
		cmp_val("fault pin", 1, fault_output_n);
		measure(kind, hold, (1 << (BASE + 2 * p)) + ((kind == 1 || (kind == 2 && ir == 0)) ? hold : 0));
		rd(STATUS_OFS, 32'h0000_0002, RESP_OKAY, "status");
	endtask

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========
	// Main sequence
	initial
	begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		rd(MODE_OFS, 32'h0000_0082, RESP_OKAY, "mode reset");
		rd(STATUS_OFS, 0, RESP_OKAY, "status reset");
		rd(12'hFFC, 0, RESP_SLVERR, "unmapped");
		n = 0;
		debug_mode <= 1'b0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (rst_req !== 1'b1 && n < 1000);
		cmp_cyc("reset delay", (1 << BASE) + 1, n);
		cmp_val("oscillator request", 1, to_osc);
		cmp_val("fault pin", 0, fault_output_n);
		m = 0;
		while (rst_req === 1'b1 && m < 100)
		begin
			m++;
			@(posedge aclk);
		end
		debug_mode <= 1'b1;
		cmp_val("hold length", 32, m);
		rd(MODE_OFS, 32'h0000_0082, RESP_OKAY, "mode after hold");
		for (int p = 0; p < 6; p++)
		begin
			run_case(p, 0, 0, 0);
			if (p == 0)
			begin
				for (int i = 0; i < 4; i++)
				begin
					m = xs() & 32'h0000_00ff;
					if (m == CODE_DISABLE || m == CODE_CLEAR)
						m ^= 1;
					wr(CMD_OFS, m);
					rd(STATUS_OFS, 32'h0000_0002, RESP_OKAY, "after reserved");
				end
				rd(CMD_OFS, 0, RESP_OKAY, "command readback");
			end
		end
		run_case(0, 0, 1, 50);
		run_case(0, 0, 2, 50);
		run_case(0, 1, 2, 50);
		wr(CMD_OFS, 32'(CODE_CLEAR));
		wr(CMD_OFS, 32'(CODE_DISABLE));
		rd(STATUS_OFS, 0, RESP_OKAY, "still enabled");
		wr(MODE_OFS, 0);
		wr(CMD_OFS, 32'(CODE_DISABLE));
		rd(STATUS_OFS, 1, RESP_OKAY, "disabled");
		debug_mode <= 1'b0;
		m = 0;
		repeat (200)
		begin
			@(posedge aclk);
			m += (irq === 1'b1 || rst_req === 1'b1);
		end
		debug_mode <= 1'b1;
		cmp_val("events while off", 0, m);
		run_case(0, 0, 0, 0);
		report_and_stop;
	end

	initial
	begin
		repeat (60000) @(posedge aclk);
		errors++;
		$display("CHECK FAILED run length expected finish seen timeout");
		report_and_stop;
	end
endmodule
